// ---- logic/acc_clkdiv.sv ----
// conversion clock divider: one tick per conversion clock period
// assumes the base converter clock is clk_sys_i
`timescale 1ns/100ps
module acc_clkdiv (
	input  wire logic clk_sys_i,
	input  wire logic reset_i,
	acc_div_if.div    div_if
);
	import acc_pkg::*;

	logic [2:0] cnt;

	// ------------------------------------------------------------------------
	// divisor decode
	// ------------------------------------------------------------------------
	// sel = {c, b, a}; with c set the a bit is ignored
	function automatic logic [2:0] divisor_of(input logic [2:0] sel);
		logic [3:0] d;
		d = 4'd4;
		case (sel)
			3'b000: d = 4'd4;
			3'b010: d = 4'd3;
			3'b001: d = 4'd2;
			3'b011: d = 4'd1;
			3'b100, 3'b101: d = 4'd8;
			default: d = 4'd6;
		endcase
		return 3'(d - 4'd1);
	endfunction

	// ------------------------------------------------------------------------
	// counter, restarted whenever no conversion runs
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || !div_if.run) begin
			cnt         <= 3'h0;
			div_if.tick <= 1'b0;
		end else if (cnt >= divisor_of(div_if.sel)) begin
			cnt         <= 3'h0;
			div_if.tick <= 1'b1;
		end else begin
			cnt         <= cnt + 3'h1;
			div_if.tick <= 1'b0;
		end
	end
endmodule

// ---- logic/acc_div_if.sv ----
// carrier between control logic and conversion clock divider
// assumes both ends share clk_sys_i
`timescale 1ns/100ps
interface acc_div_if;
	logic [2:0] sel;
	logic       run;
	logic       tick;

	modport ctl (output sel, output run, input tick);
	modport div (input sel, input run, output tick);
endinterface

// ---- logic/acc_pkg.sv ----
// types shared by the converter control block
// assumes the register header supplies all numbers
package acc_pkg;
	typedef enum logic [1:0] {
		ACC_ST_IDLE,
		ACC_ST_ARMED,
		ACC_ST_CONV
	} acc_state_t;

	typedef enum logic [1:0] {
		ACC_MD_ONESHOT,
		ACC_MD_REPEAT,
		ACC_MD_SWEEP,
		ACC_MD_RSWEEP
	} acc_mode_t;
endpackage

// ---- logic/acc_regs.svh ----
// register offsets, field positions, reset values and timing counts of the
// converter control block; assumes a 12-bit APB byte address
//
// Behaviour
// - conversion clock divides base clock by 4,3,2,1 or, with third bit set, 8,6.
// - DMA result mode stores every result in the first result register.
// - program reads of results are undefined while DMA collects results.
// - software writes to result registers leave no defined content.
// - start on flag write under software trigger, else trigger falling edge.
// - completion raises interrupt; one-shot software trigger clears start flag.
// - clearing reference connect cuts ladder reference supply.
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// ----------------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------------
`define ACC_OFF_CTRL0   12'h000
`define ACC_OFF_CTRL1   12'h004
`define ACC_OFF_CTRL2   12'h008
`define ACC_OFF_CTRL3   12'h00C
`define ACC_OFF_CTRL4   12'h010
`define ACC_OFF_RES0    12'h020
`define ACC_OFF_RES7    12'h03C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define ACC_C0_CHAN_LSB   0
`define ACC_C0_MODE_LO    3
`define ACC_C0_MODE_HI    4
`define ACC_C0_TRG_KIND   5
`define ACC_C0_START      6
`define ACC_C0_DIV_A      7
`define ACC_C1_SCAN_LO    0
`define ACC_C1_SCAN_HI    1
`define ACC_C1_SWEEP1     2
`define ACC_C1_RES10      3
`define ACC_C1_DIV_B      4
`define ACC_C1_REF_CONN   5
`define ACC_C1_EXT_LO     6
`define ACC_C1_EXT_HI     7
`define ACC_C2_SAMPHOLD   0
`define ACC_C2_GRP_LO     1
`define ACC_C2_GRP_HI     2
`define ACC_C2_TRG_SRC    5
`define ACC_C3_MPSWEEP    0
`define ACC_C3_DMA_MODE   1
`define ACC_C3_DIV_C      2
`define ACC_C4_MPGRP_LO   2
`define ACC_C4_MPGRP_HI   3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ACC_CTRL_RST    8'h00
`define ACC_RES_RST     10'h000

// ----------------------------------------------------------------------------
// conversion lengths in conversion clock cycles
// ----------------------------------------------------------------------------
`define ACC_CONV_8      7'd49
`define ACC_CONV_10     7'd59
`define ACC_CONV_SH_8   7'd28
`define ACC_CONV_SH_10  7'd33

`endif

// ---- logic/acc_top.sv ----
// converter control and configuration logic with APB register access
// assumes synchronous inputs on clk_sys_i and an analog core sampled at end
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "acc_regs.svh"
module acc_top (
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        external_trigger_pin_i,
	input  wire logic        hw_trigger_i,
	input  wire logic [9:0]  adc_sample_i,
	output logic             conv_busy_o,
	output logic [2:0]       conv_channel_o,
	output logic             reference_connect_o,
	output logic             conv_done_irq_o,
	output logic             dma_req_o
);
	import acc_pkg::*;

	acc_div_if div_if ();

	acc_clkdiv u_div (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.div_if    (div_if)
	);

	logic [7:0]  ctrl0;
	logic [7:0]  ctrl1;
	logic [7:0]  ctrl2;
	logic [7:0]  ctrl3;
	logic [7:0]  ctrl4;
	logic [9:0]  res_q [0:7];
	acc_state_t  state;
	logic [6:0]  tick_cnt;
	logic        trig_prev;
	logic        wr_en;
	logic        trig_evt;
	logic        conv_done;
	logic        last_pin;
	logic        clear_start;
	logic [6:0]  conv_len;
	logic [2:0]  next_channel;
	acc_mode_t   mode;

	// ------------------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------------------
	// highest pin index of a sweep from the pin count field
	function automatic logic [2:0] sweep_last(input logic [1:0] cnt);
		return {cnt, 1'b1};
	endfunction

	// ------------------------------------------------------------------------
	// apb slave, zero wait states
	// ------------------------------------------------------------------------
	// write lands in the access cycle, when pready is high
	assign wr_en = psel_i && penable_i && pwrite_i && pready_o && pstrb_i[0];

	// answer prepared during the setup cycle
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0;
		end else begin
			pready_o  <= psel_i && !penable_i;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0;
			if (psel_i && !penable_i) begin
				if (paddr_i == `ACC_OFF_CTRL0) begin
					prdata_o <= {24'h0, ctrl0};
				end else if (paddr_i == `ACC_OFF_CTRL1) begin
					prdata_o <= {24'h0, ctrl1};
				end else if (paddr_i == `ACC_OFF_CTRL2) begin
					prdata_o <= {24'h0, ctrl2};
				end else if (paddr_i == `ACC_OFF_CTRL3) begin
					prdata_o <= {24'h0, ctrl3}; // plain storage, stable also while converting
				end else if (paddr_i == `ACC_OFF_CTRL4) begin
					prdata_o <= {24'h0, ctrl4};
				end else if (paddr_i >= `ACC_OFF_RES0 && paddr_i <= `ACC_OFF_RES7
						&& paddr_i[1:0] == 2'b00) begin
					// under dma collection the value is not guaranteed
					prdata_o <= {22'h0, res_q[paddr_i[4:2]]};
				end else begin
					pslverr_o <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------------
	// start flag: hardware clear, but a software write in the same cycle wins
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			ctrl0 <= `ACC_CTRL_RST;
		end else if (wr_en && paddr_i == `ACC_OFF_CTRL0) begin
			ctrl0 <= pwdata_i[7:0];
		end else if (clear_start) begin
			ctrl0[`ACC_C0_START] <= 1'b0;
		end
	end

	// remaining control registers, plain storage
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			ctrl1 <= `ACC_CTRL_RST;
			ctrl2 <= `ACC_CTRL_RST;
			ctrl3 <= `ACC_CTRL_RST;
			ctrl4 <= `ACC_CTRL_RST;
		end else if (wr_en) begin
			if (paddr_i == `ACC_OFF_CTRL1) begin
				ctrl1 <= pwdata_i[7:0];
			end else if (paddr_i == `ACC_OFF_CTRL2) begin
				ctrl2 <= pwdata_i[7:0];
			end else if (paddr_i == `ACC_OFF_CTRL3) begin
				ctrl3 <= pwdata_i[7:0];
			end else if (paddr_i == `ACC_OFF_CTRL4) begin
				ctrl4 <= pwdata_i[7:0];
			end
		end
	end

	// reference supply to the ladder follows its connect bit
	assign reference_connect_o = ctrl1[`ACC_C1_REF_CONN];

	// divider select bits gathered from three registers
	assign div_if.sel = {ctrl3[`ACC_C3_DIV_C], ctrl1[`ACC_C1_DIV_B], ctrl0[`ACC_C0_DIV_A]};
	assign div_if.run = (state == ACC_ST_CONV);

	// ------------------------------------------------------------------------
	// sequencing decode
	// ------------------------------------------------------------------------
	always_comb begin
		mode     = acc_mode_t'({ctrl0[`ACC_C0_MODE_HI], ctrl0[`ACC_C0_MODE_LO]});
		// trigger source 0 is the pin falling edge, 1 the timer request
		trig_evt = ctrl2[`ACC_C2_TRG_SRC] ? hw_trigger_i
			: (trig_prev && !external_trigger_pin_i);
		case ({ctrl2[`ACC_C2_SAMPHOLD], ctrl1[`ACC_C1_RES10]})
			2'b00:   conv_len = `ACC_CONV_8;
			2'b01:   conv_len = `ACC_CONV_10;
			2'b10:   conv_len = `ACC_CONV_SH_8;
			default: conv_len = `ACC_CONV_SH_10;
		endcase
		conv_done = (state == ACC_ST_CONV) && div_if.tick
			&& (tick_cnt == conv_len - 7'd1);
		last_pin  = (conv_channel_o == sweep_last(
			{ctrl1[`ACC_C1_SCAN_HI], ctrl1[`ACC_C1_SCAN_LO]}));
		// single passes under software trigger end by clearing the flag
		clear_start = conv_done && !ctrl0[`ACC_C0_TRG_KIND]
			&& (mode == ACC_MD_ONESHOT || (mode == ACC_MD_SWEEP && last_pin));
		if (mode == ACC_MD_ONESHOT || mode == ACC_MD_REPEAT || last_pin) begin
			next_channel = (mode == ACC_MD_ONESHOT || mode == ACC_MD_REPEAT)
				? ctrl0[2:0] : 3'h0;
		end else begin
			next_channel = conv_channel_o + 3'h1;
		end
	end

	// falling edge detector of the trigger pin
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			trig_prev <= 1'b1;
		end else begin
			trig_prev <= external_trigger_pin_i;
		end
	end

	// ------------------------------------------------------------------------
	// conversion state machine
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state          <= ACC_ST_IDLE;
			tick_cnt       <= 7'h0;
			conv_busy_o    <= 1'b0;
			conv_channel_o <= 3'h0;
		end else if (!ctrl0[`ACC_C0_START]) begin
			// clearing the flag stops any conversion
			state       <= ACC_ST_IDLE;
			tick_cnt    <= 7'h0;
			conv_busy_o <= 1'b0;
		end else begin
			case (state)
				ACC_ST_IDLE: begin
					conv_channel_o <= (mode == ACC_MD_ONESHOT || mode == ACC_MD_REPEAT)
						? ctrl0[2:0] : 3'h0;
					tick_cnt <= 7'h0;
					if (ctrl0[`ACC_C0_TRG_KIND]) begin
						state <= ACC_ST_ARMED; // flag then awaits trigger
					end else begin
						state       <= ACC_ST_CONV; // software start
						conv_busy_o <= 1'b1;
					end
				end
				ACC_ST_ARMED: begin
					if (trig_evt) begin
						state       <= ACC_ST_CONV;
						conv_busy_o <= 1'b1;
						tick_cnt    <= 7'h0;
					end
				end
				default: begin
					if (ctrl0[`ACC_C0_TRG_KIND] && trig_evt) begin
						// retrigger restarts from the first pin
						tick_cnt       <= 7'h0;
						conv_channel_o <= (mode == ACC_MD_ONESHOT || mode == ACC_MD_REPEAT)
							? ctrl0[2:0] : 3'h0;
					end else if (conv_done) begin
						tick_cnt       <= 7'h0;
						conv_channel_o <= next_channel;
						if (mode == ACC_MD_ONESHOT || (mode == ACC_MD_SWEEP && last_pin)) begin
							state       <= ctrl0[`ACC_C0_TRG_KIND] ? ACC_ST_ARMED : ACC_ST_IDLE;
							conv_busy_o <= 1'b0;
						end
					end else if (div_if.tick) begin
						tick_cnt <= tick_cnt + 7'h1;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// results and completion events
	// ------------------------------------------------------------------------
	// software writes to results are dropped, content stays converter-owned
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			for (int i = 0; i < 8; i++) begin
				res_q[i] <= `ACC_RES_RST;
			end
		end else if (conv_done) begin // no write path
			// dma mode funnels every result into the first slot
			res_q[ctrl3[`ACC_C3_DMA_MODE] ? 3'h0 : conv_channel_o] <=
				ctrl1[`ACC_C1_RES10] ? adc_sample_i
				: {2'b00, adc_sample_i[9:2]};
		end
	end

	// one-cycle completion pulses
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			conv_done_irq_o <= 1'b0;
			dma_req_o       <= 1'b0;
		end else begin
			conv_done_irq_o <= conv_done;
			dma_req_o       <= conv_done && ctrl3[`ACC_C3_DMA_MODE];
		end
	end
endmodule

// ---- tb/acc_monitor.sv ----
// port checker of the converter control block
// assumes it is bound onto acc_top, one clock domain
`timescale 1ns/100ps
`include "acc_regs.svh"
module acc_monitor (
	input wire logic        clk_sys_i,
	input wire logic        reset_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0]  pstrb_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        conv_busy_o,
	input wire logic        reference_connect_o,
	input wire logic        conv_done_irq_o,
	input wire logic        dma_req_o
);
	logic       wr_acc;
	logic [2:0] c0_kind;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	// completed write of the low byte
	assign wr_acc = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];
	// shadow of mode and trigger kind bits
	always_ff @(posedge clk_sys_i) begin
		if (reset_i)
			c0_kind <= 3'h0;
		else if (wr_acc && paddr_i == `ACC_OFF_CTRL0)
			c0_kind <= pwdata_i[5:3];
	end
	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------
	a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
		else $error("pready missing after setup");
	a_ready_single: assert property (pready_o |=> !pready_o)
		else $error("pready longer than one cycle");
	a_err_unmapped: assert property (psel_i && penable_i && pready_o
		&& paddr_i > `ACC_OFF_RES7 |-> pslverr_o)
		else $error("unmapped access without error");
	a_rdata_quiet: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
		else $error("read data outside access");
	a_ref_follows: assert property (wr_acc && paddr_i == `ACC_OFF_CTRL1
		|=> reference_connect_o == $past(pwdata_i[5]))
		else $error("reference connect not following write");
	a_sw_start: assert property (wr_acc && paddr_i == `ACC_OFF_CTRL0
		&& pwdata_i[6] && !pwdata_i[5] && !conv_busy_o |-> ##[1:2] conv_busy_o)
		else $error("software start did not begin");
	a_irq_pulse: assert property (conv_done_irq_o |=> !conv_done_irq_o)
		else $error("completion pulse too long");
	a_oneshot_stop: assert property (conv_done_irq_o && c0_kind == 3'h0
		|-> ##[0:2] !conv_busy_o)
		else $error("one-shot did not stop");
	a_dma_with_done: assert property (dma_req_o
		|-> conv_done_irq_o || $past(conv_done_irq_o))
		else $error("dma request without completion");
	// main scenarios
	c_done: cover property (conv_done_irq_o);
	c_dma: cover property (dma_req_o);
	c_err: cover property (pslverr_o);
	c_busy: cover property ($rose(conv_busy_o));
endmodule
bind acc_top acc_monitor u_acc_monitor (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .conv_busy_o(conv_busy_o),
	.reference_connect_o(reference_connect_o), .conv_done_irq_o(conv_done_irq_o),
	.dma_req_o(dma_req_o));

// ---- tb/test_acc_top.sv ----
// self-checking bench of the converter control block
// assumes acc_top alone, checker bound onto it
`timescale 1ns/100ps
`include "acc_regs.svh"
module test_acc_top;
	logic        clk_sys_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic [3:0]  pstrb_i = 4'hF;
	logic        pin_i = 1'b1;
	logic        hw_trigger_i = 1'b0;
	logic [9:0]  adc_sample_i = 10'h000;
	logic [31:0] prdata_o;
	logic        pready_o, pslverr_o, conv_busy_o, reference_connect_o;
	logic        conv_done_irq_o, dma_req_o;
	logic [2:0]  conv_channel_o;
	logic [31:0] rd, v;
	logic        er;
	logic [2:0]  s, ch;
	logic [2:0]  tbl [6] = '{3'b011, 3'b000, 3'b010, 3'b001, 3'b100, 3'b110};
	int          failures = 0, check_count = 0, dma_cnt = 0, n, t1, seed;
	acc_top u_acc_top (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .external_trigger_pin_i(pin_i),
		.hw_trigger_i(hw_trigger_i), .adc_sample_i(adc_sample_i),
		.conv_busy_o(conv_busy_o), .conv_channel_o(conv_channel_o),
		.reference_connect_o(reference_connect_o), .conv_done_irq_o(conv_done_irq_o),
		.dma_req_o(dma_req_o));
	// ------------------------------------------------------------------------
	// clock, counters, helpers
	// ------------------------------------------------------------------------
	initial forever #25 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) if (dma_req_o === 1'b1) dma_cnt <= dma_cnt + 1;
	function automatic int div_of(input logic [2:0] sel);
		return sel[2] ? (sel[1] ? 6 : 8) : (4 >> sel[0]) - (sel[1] && !sel[0] ? 1 : 0)
			- (sel[1] && sel[0] ? 1 : 0);
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one apb transfer, held until pready is sampled high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int w;
		w = 0;
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		// values read right at the edge are those before this edge's updates
		do begin
			@(posedge clk_sys_i);
			w++;
		end while (pready_o !== 1'b1 && w < 20);
		if (pready_o !== 1'b1) failures++;
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wait_irq(output int cnt);
		cnt = 0;
		do begin
			@(negedge clk_sys_i);
			cnt++;
		end while (conv_done_irq_o !== 1'b1 && cnt < 3000);
		if (cnt >= 3000) failures++;
	endtask
	task automatic results;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#(20000 * 50);
		failures++;
		results();
	end
	// ------------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------------
	initial begin
		seed = $urandom(9921);
		repeat (6) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		// random control bytes read back while stopped
		for (int k = 1; k < 5; k++) begin
			v = $urandom & 32'h0000_00FF;
			apb(1'b1, 12'(4 * k), v); // written while stopped
			apb(1'b0, 12'(4 * k), 32'h0);
			check("ctrl readback", rd, v);
		end
		apb(1'b0, 12'h100, 32'h0);
		check("unmapped error", {31'h0, er}, 32'h1);
		apb(1'b1, `ACC_OFF_RES0, $urandom);
		apb(1'b0, `ACC_OFF_RES0, 32'h0);
		check("result write ignored", rd, 32'h0);
		apb(1'b1, `ACC_OFF_CTRL2, 32'h0); // input group 00b
		apb(1'b1, `ACC_OFF_CTRL4, 32'h0); // group 00b while sweep off
		// every divisor, lengths against the divide-by-one run
		for (int i = 0; i < 6; i++) begin
			s = tbl[i];
			ch = 3'($urandom);
			adc_sample_i <= 10'($urandom);
			apb(1'b1, `ACC_OFF_CTRL3, {29'h0, s[2], 2'b00}); // sweep off
			apb(1'b1, `ACC_OFF_CTRL1, {27'h0, 1'b1, s[1], 4'h0}); // ext 00b
			repeat (20) @(posedge clk_sys_i);
			check("reference on", {31'h0, reference_connect_o}, 32'h1);
			apb(1'b1, `ACC_OFF_CTRL0, {24'h0, s[0], 4'h8, ch}); // mode, pin
			wait_irq(n);
			check("channel", {29'h0, conv_channel_o}, {29'h0, ch});
			if (i == 0)
				t1 = n;
			else
				check("conversion length", n, t1 + 49 * (div_of(s) - 1));
			apb(1'b0, `ACC_OFF_CTRL0, 32'h0);
			check("start flag cleared", {31'h0, rd[6]}, 32'h0);
			apb(1'b0, 12'(`ACC_OFF_RES0 + 4 * ch), 32'h0);
			check("result", rd, {24'h0, adc_sample_i[9:2]});
		end
		// dma result mode collects into the first result register
		adc_sample_i <= 10'($urandom);
		apb(1'b1, `ACC_OFF_CTRL3, 32'h2);
		apb(1'b1, `ACC_OFF_CTRL0, 32'h45);
		wait_irq(n);
		apb(1'b0, `ACC_OFF_RES0, 32'h0);
		check("dma result", rd, {24'h0, adc_sample_i[9:2]});
		check("dma requests", dma_cnt, 1);
		apb(1'b1, `ACC_OFF_CTRL3, 32'h0);
		// multi-port single sweep at 10-bit resolution, divide by one
		adc_sample_i <= 10'($urandom);
		apb(1'b1, `ACC_OFF_CTRL1, 32'h3B); // count 11b, ext 00b
		apb(1'b1, `ACC_OFF_CTRL2, 32'h2); // input group 01b
		apb(1'b1, `ACC_OFF_CTRL3, 32'h3); // sweep with dma mode
		apb(1'b1, `ACC_OFF_CTRL4, 32'h4); // group non-zero while sweeping
		apb(1'b1, `ACC_OFF_CTRL0, 32'hD0); // mode 10b, pin 0
		for (int j = 0; j < 8; j++)
			wait_irq(n);
		check("sweep stopped", {31'h0, conv_busy_o}, 32'h0);
		apb(1'b0, `ACC_OFF_CTRL0, 32'h0);
		check("sweep flag cleared", {31'h0, rd[6]}, 32'h0);
		check("sweep dma requests", dma_cnt, 9);
		apb(1'b0, `ACC_OFF_RES0, 32'h0);
		check("sweep result", {16'h0, rd[15:0]}, {22'h0, adc_sample_i});
		apb(1'b1, `ACC_OFF_CTRL3, 32'h0);
		apb(1'b1, `ACC_OFF_CTRL4, 32'h0);
		// trigger pin then timer trigger
		for (int src = 0; src < 2; src++) begin
			apb(1'b1, `ACC_OFF_CTRL2, src ? 32'h20 : 32'h0);
			apb(1'b1, `ACC_OFF_CTRL0, 32'h20);
			apb(1'b1, `ACC_OFF_CTRL0, 32'h60);
			repeat (5) @(negedge clk_sys_i);
			check("armed idle", {31'h0, conv_busy_o}, 32'h0);
			@(posedge clk_sys_i);
			if (src == 0)
				pin_i <= 1'b0;
			else
				hw_trigger_i <= 1'b1;
			@(posedge clk_sys_i);
			hw_trigger_i <= 1'b0;
			repeat (2) @(negedge clk_sys_i);
			check("triggered busy", {31'h0, conv_busy_o}, 32'h1);
			wait_irq(n);
			@(posedge clk_sys_i);
			pin_i <= 1'b1;
			apb(1'b1, `ACC_OFF_CTRL0, 32'h0);
		end
		results();
	end
endmodule
